// ---- inc/sxsa_pkg.sv ----
package sxsa_pkg;

    // Datapath widths.
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIB_W  = 4;
    localparam int OP_W   = 3;

    // Operation codes on the operation port.
    localparam logic [OP_W-1:0] OP_SUB_ACC_FROM_LITERAL = 3'h0;
    localparam logic [OP_W-1:0] OP_SUB_ACC_FROM_FILE    = 3'h1;
    localparam logic [OP_W-1:0] OP_XOR_LITERAL_ACC      = 3'h2;
    localparam logic [OP_W-1:0] OP_XOR_ACC_FILE         = 3'h3;
    localparam logic [OP_W-1:0] OP_SWAP_FILE_NIBBLES    = 3'h4;

    // Destination select values.
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Reset values of the architectural state.
    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic              FLAG_RESET = 1'b0;

endpackage

// ---- design/sxsa_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

// Combinational operation unit: result, flags and which flags the operation touches.
module sxsa_unit #(
    parameter int DATA_W = sxsa_pkg::DATA_W,
    parameter int NIB_W  = sxsa_pkg::NIB_W
) (
    // Operation and operands.
    input  wire logic [sxsa_pkg::OP_W-1:0] op,
    input  wire logic [DATA_W-1:0]         acc,
    input  wire logic [DATA_W-1:0]         literal,
    input  wire logic [DATA_W-1:0]         file_data,
    // Results.
    output logic [DATA_W-1:0]              result,
    output logic                           carry,
    output logic                           digit_carry,
    output logic                           zero,
    output logic                           upd_carry,
    output logic                           upd_zero,
    output logic                           legal
);

    logic [DATA_W-1:0] minuend;   // Literal or file value, the side the accumulator is taken from.
    logic [DATA_W:0]   diff_wide; // One extra bit holds the borrow out.
    logic [NIB_W:0]    diff_low;  // Low nibble difference with its borrow.
    logic [DATA_W-1:0] swapped;   // File value with its nibbles exchanged.

    // Nibble exchange, one assignment per bit.
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_swap
            assign swapped[gi] = file_data[(gi + NIB_W) % DATA_W];
        end
    endgenerate

    // Borrow logic is shared by both subtract flavours; only the minuend differs.
    always_comb begin
        minuend     = (op == sxsa_pkg::OP_SUB_ACC_FROM_LITERAL) ? literal : file_data;
        diff_wide   = {1'b0, minuend} - {1'b0, acc};
        diff_low    = {1'b0, minuend[NIB_W-1:0]} - {1'b0, acc[NIB_W-1:0]};
        result      = acc;
        upd_carry   = 1'b0;
        upd_zero    = 1'b0;
        legal       = 1'b1;
        // Carry means no borrow: the accumulator did not exceed the other operand.
        carry       = ~diff_wide[DATA_W];
        digit_carry = ~diff_low[NIB_W];
        case (op)
            sxsa_pkg::OP_SUB_ACC_FROM_LITERAL,
            sxsa_pkg::OP_SUB_ACC_FROM_FILE: begin
                result    = diff_wide[DATA_W-1:0];
                upd_carry = 1'b1;
                upd_zero  = 1'b1;
            end
            sxsa_pkg::OP_XOR_LITERAL_ACC: begin
                result   = acc ^ literal;
                upd_zero = 1'b1;
            end
            sxsa_pkg::OP_XOR_ACC_FILE: begin
                result   = acc ^ file_data;
                upd_zero = 1'b1;
            end
            sxsa_pkg::OP_SWAP_FILE_NIBBLES: begin
                result = swapped;
            end
            default: begin
                // Unknown codes do nothing at all.
                legal = 1'b0;
            end
        endcase
        zero = (result == '0);
    end

endmodule

`default_nettype wire

// ---- design/sxsa_alu.sv ----
`timescale 1ns/1ps
`default_nettype none

module sxsa_alu #(
    parameter int DATA_W = sxsa_pkg::DATA_W,
    parameter int ADDR_W = sxsa_pkg::ADDR_W
) (
    // Clock, reset and clock enable.
    input  wire logic                      CLK,
    input  wire logic                      RESET_N,
    input  wire logic                      CE,
    // Operation request from the core sequencer.
    input  wire logic                      OP_VALID,
    input  wire logic [sxsa_pkg::OP_W-1:0] OP_CODE,
    input  wire logic [DATA_W-1:0]         LITERAL,
    input  wire logic [ADDR_W-1:0]         FILE_ADDR,
    input  wire logic                      DEST_SEL,
    input  wire logic [DATA_W-1:0]         FILE_RDATA,
    // Direct accumulator load.
    input  wire logic                      ACC_LOAD,
    input  wire logic [DATA_W-1:0]         ACC_LOAD_DATA,
    // Architectural state.
    output logic [DATA_W-1:0]              ACC,
    output logic                           CARRY,
    output logic                           DIGIT_CARRY,
    output logic                           ZERO,
    // Register file write port.
    output logic                           FILE_WE,
    output logic [ADDR_W-1:0]              FILE_WADDR,
    output logic [DATA_W-1:0]              FILE_WDATA,
    // Completion strobe.
    output logic                           DONE
);

    // Registered state and its next values.
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic              c_reg, c_next;
    logic              digc_reg, digc_next;
    logic              z_reg, z_next;
    logic              we_reg, we_next;
    logic [ADDR_W-1:0] waddr_reg, waddr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic              done_reg, done_next;

    // Operation unit outputs.
    logic [DATA_W-1:0] u_result;
    logic              u_carry;
    logic              u_digc;
    logic              u_zero;
    logic              u_upd_carry;
    logic              u_upd_zero;
    logic              u_legal;

    // An operation is taken only on an enabled cycle with a legal code.
    logic fire;
    logic to_file;

    sxsa_unit #(
        .DATA_W (DATA_W),
        .NIB_W  (sxsa_pkg::NIB_W)
    ) u_unit (
        .op          (OP_CODE),
        .acc         (acc_reg),
        .literal     (LITERAL),
        .file_data   (FILE_RDATA),
        .result      (u_result),
        .carry       (u_carry),
        .digit_carry (u_digc),
        .zero        (u_zero),
        .upd_carry   (u_upd_carry),
        .upd_zero    (u_upd_zero),
        .legal       (u_legal)
    );

    // Next-state computation. Literal ops always land in the accumulator,
    // whatever the destination select says, since they have no file operand.
    always_comb begin
        fire       = CE && OP_VALID && u_legal;
        to_file    = (DEST_SEL == sxsa_pkg::DEST_FILE)
                     && (OP_CODE != sxsa_pkg::OP_SUB_ACC_FROM_LITERAL)
                     && (OP_CODE != sxsa_pkg::OP_XOR_LITERAL_ACC);
        acc_next   = acc_reg;
        c_next     = c_reg;
        digc_next  = digc_reg;
        z_next     = z_reg;
        we_next    = 1'b0;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        done_next  = 1'b0;
        if (fire) begin
            done_next = 1'b1;
            // Destination select picks accumulator or file write.
            if (to_file) begin
                we_next    = 1'b1;
                waddr_next = FILE_ADDR;
                wdata_next = u_result;
            end else begin
                acc_next = u_result;
            end
            // Flags move only for the operations that own them; swap leaves all alone.
            if (u_upd_carry) begin
                c_next  = u_carry;
                digc_next = u_digc;
            end
            if (u_upd_zero) begin
                z_next = u_zero;
            end
        end else if (CE && ACC_LOAD) begin
            // A direct load that collides with a taken operation is dropped; the operation wins.
            acc_next = ACC_LOAD_DATA;
        end else if (!CE) begin
            // Strobes hold while frozen so no pulse is lost or doubled.
            we_next   = we_reg;
            done_next = done_reg;
        end
    end

    // State registers; synchronous reset to package constants.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            acc_reg   <= sxsa_pkg::ACC_RESET;
            c_reg     <= sxsa_pkg::FLAG_RESET;
            digc_reg  <= sxsa_pkg::FLAG_RESET;
            z_reg     <= sxsa_pkg::FLAG_RESET;
            we_reg    <= 1'b0;
            waddr_reg <= sxsa_pkg::ADDR_RESET;
            wdata_reg <= sxsa_pkg::ACC_RESET;
            done_reg  <= 1'b0;
        end else begin
            acc_reg   <= acc_next;
            c_reg     <= c_next;
            digc_reg  <= digc_next;
            z_reg     <= z_next;
            we_reg    <= we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            done_reg  <= done_next;
        end
    end

    // Outputs straight from flip-flops.
    assign ACC         = acc_reg;
    assign CARRY       = c_reg;
    assign DIGIT_CARRY = digc_reg;
    assign ZERO        = z_reg;
    assign FILE_WE     = we_reg;
    assign FILE_WADDR  = waddr_reg;
    assign FILE_WDATA  = wdata_reg;
    assign DONE        = done_reg;

    // Helper: the value the last operation actually wrote, wherever it went.
    logic [DATA_W-1:0] written;
    assign written = FILE_WE ? FILE_WDATA : ACC;

    // Every property below runs on the core clock and rests while reset is held.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // Literal subtract always lands in the accumulator, whatever the destination bit says.
    sub_lit_value_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_SUB_ACC_FROM_LITERAL
        |=> ACC == DATA_W'($past(LITERAL) - $past(ACC)) && DONE && !FILE_WE)
        else $error("literal subtract result wrong");
    // Literal subtract carries: set when no borrow, on the whole byte and on the low nibble.
    lit_carry_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_SUB_ACC_FROM_LITERAL
        |=> CARRY == ($past(ACC) <= $past(LITERAL))
            && DIGIT_CARRY == ($past(ACC[sxsa_pkg::NIB_W-1:0]) <= $past(LITERAL[sxsa_pkg::NIB_W-1:0])))
        else $error("literal subtract carry flags wrong");
    // File subtract carries follow the same no-borrow rule.
    sub_carry_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_SUB_ACC_FROM_FILE
        |=> CARRY == ($past(ACC) <= $past(FILE_RDATA))
            && DIGIT_CARRY == ($past(ACC[sxsa_pkg::NIB_W-1:0]) <= $past(FILE_RDATA[sxsa_pkg::NIB_W-1:0])))
        else $error("file subtract carry flags wrong");
    // File subtract value goes where the destination bit points.
    sub_file_dest_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_SUB_ACC_FROM_FILE
        |=> DONE && FILE_WE == $past(DEST_SEL) && written == DATA_W'($past(FILE_RDATA) - $past(ACC)))
        else $error("file subtract result or destination wrong");
    // Literal XOR leaves both carry flags alone.
    xor_lit_value_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_XOR_LITERAL_ACC
        |=> ACC == ($past(LITERAL) ^ $past(ACC)) && $stable(CARRY) && $stable(DIGIT_CARRY))
        else $error("literal xor wrong");
    // Nibble swap touches no flag and honours the destination bit.
    swap_flags_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_SWAP_FILE_NIBBLES
        |=> $stable(CARRY) && $stable(ZERO) && $stable(DIGIT_CARRY) && FILE_WE == $past(DEST_SEL)
            && written == {$past(FILE_RDATA[sxsa_pkg::NIB_W-1:0]), $past(FILE_RDATA[DATA_W-1:sxsa_pkg::NIB_W])})
        else $error("nibble swap wrong");
    // File XOR with the file destination writes back and keeps the accumulator.
    xor_file_dest_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_XOR_ACC_FILE && DEST_SEL
        |=> FILE_WE && FILE_WADDR == $past(FILE_ADDR) && $stable(ACC)
            && FILE_WDATA == ($past(ACC) ^ $past(FILE_RDATA)))
        else $error("file xor destination wrong");
    // File XOR with the accumulator destination writes no file register.
    xor_file_acc_a: assert property (
        CE && OP_VALID && OP_CODE == sxsa_pkg::OP_XOR_ACC_FILE && !DEST_SEL
        |=> !FILE_WE && ACC == ($past(ACC) ^ $past(FILE_RDATA)) && $stable(CARRY))
        else $error("accumulator xor destination wrong");
    // Zero follows the value written by every operation that owns the flag. Checked from the
    // taking edge, so a frozen cycle after a swap cannot be mistaken for a zero update.
    zero_flag_a: assert property (
        CE && OP_VALID
        && (OP_CODE == sxsa_pkg::OP_SUB_ACC_FROM_LITERAL || OP_CODE == sxsa_pkg::OP_SUB_ACC_FROM_FILE
            || OP_CODE == sxsa_pkg::OP_XOR_LITERAL_ACC || OP_CODE == sxsa_pkg::OP_XOR_ACC_FILE)
        |=> ZERO == (written == '0))
        else $error("zero flag disagrees with result");
    // Unused codes change nothing and raise no strobe.
    illegal_code_a: assert property (
        CE && OP_VALID && OP_CODE > sxsa_pkg::OP_SWAP_FILE_NIBBLES && !ACC_LOAD
        |=> !DONE && !FILE_WE && $stable(ACC) && $stable(ZERO) && $stable(CARRY) && $stable(DIGIT_CARRY))
        else $error("unused code changed state");
    // A low clock enable freezes every register, the strobes included.
    state_freeze_a: assert property (
        !CE
        |=> $stable(ACC) && $stable(ZERO) && $stable(CARRY) && $stable(DIGIT_CARRY)
            && $stable(DONE) && $stable(FILE_WE))
        else $error("state moved while clock enable low");

    // Main scenarios worth seeing at least once.
    sub_borrow_c: cover property (CE && OP_VALID && OP_CODE == sxsa_pkg::OP_SUB_ACC_FROM_FILE ##1 !CARRY);
    xor_zero_c:   cover property (CE && OP_VALID && OP_CODE == sxsa_pkg::OP_XOR_ACC_FILE ##1 ZERO);
    swap_file_c:  cover property (CE && OP_VALID && OP_CODE == sxsa_pkg::OP_SWAP_FILE_NIBBLES ##1 FILE_WE);
    hold_done_c:  cover property (DONE && !CE);

endmodule

`default_nettype wire

// ---- test/tb_subtract_xor_swap_alu.sv ----
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench: each task drives one scenario and compares against a reference worked out here.
module tb_subtract_xor_swap_alu;
    // Stimulus, all given a value at time zero.
    logic       clk           = 1'b0;
    logic       reset_n       = 1'b0;
    logic       ce            = 1'b1;
    logic       op_valid      = 1'b0;
    logic [2:0] op_code       = 3'h0;
    logic [7:0] literal       = 8'h00;
    logic [6:0] file_addr     = 7'h00;
    logic       dest_sel      = 1'b0;
    logic [7:0] file_rdata    = 8'h00;
    logic       acc_load      = 1'b0;
    logic [7:0] acc_load_data = 8'h00;
    // Observed outputs.
    logic [7:0] acc;
    logic       carry;
    logic       digit_carry;
    logic       zero;
    logic       file_we;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata;
    logic       done;
    // Reference state and bookkeeping.
    logic [7:0] e_acc = 8'h00;
    logic       e_c   = 1'b0;
    logic       e_digc = 1'b0;
    logic       e_z   = 1'b0;
    int         failures        = 0;
    int         samples_checked = 0;
    int         cycles          = 0;

    sxsa_alu u_dut (
        .CLK(clk), .RESET_N(reset_n), .CE(ce), .OP_VALID(op_valid), .OP_CODE(op_code),
        .LITERAL(literal), .FILE_ADDR(file_addr), .DEST_SEL(dest_sel), .FILE_RDATA(file_rdata),
        .ACC_LOAD(acc_load), .ACC_LOAD_DATA(acc_load_data), .ACC(acc), .CARRY(carry),
        .DIGIT_CARRY(digit_carry), .ZERO(zero), .FILE_WE(file_we), .FILE_WADDR(file_waddr),
        .FILE_WDATA(file_wdata), .DONE(done)
    );

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end

    // Hang guard; the whole run needs well under a hundred cycles per scenario.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            print_verdict();
        end
    end

    // Verdict and end of run.
    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Case-equality compare; a 1-bit value is widened so an unknown still mismatches.
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Direct accumulator load; flags are left alone by it.
    task automatic load(logic [7:0] v);
        @(posedge clk);
        acc_load      <= 1'b1;
        acc_load_data <= v;
        @(posedge clk);
        acc_load <= 1'b0;
        #1;
        e_acc = v;
        chk("acc load", v, acc);
    endtask

    // One request with the given clock enable, then a full comparison one cycle later.
    task automatic run_op(logic [2:0] op, logic [7:0] k, logic [6:0] a, logic d, logic [7:0] f, logic go);
        logic [7:0] r;
        logic [7:0] src;
        logic       ok;
        logic       wr;
        ok  = go && (op <= 3'h4);
        wr  = 1'b0;
        r   = e_acc;
        src = (op == 3'h0 || op == 3'h2) ? k : f;
        case (op)
            3'h0, 3'h1: begin
                r = src - e_acc;
                wr = (op == 3'h1) && d;
                if (ok) begin
                    e_c  = e_acc <= src;
                    e_digc = e_acc[3:0] <= src[3:0];
                    e_z  = r == 8'h00;
                end
            end
            3'h2, 3'h3: begin
                r = e_acc ^ src;
                wr = (op == 3'h3) && d;
                if (ok) begin
                    e_z = r == 8'h00;
                end
            end
            3'h4: begin
                r = {f[3:0], f[7:4]};
                wr = d;
            end
            default: begin
                wr = 1'b0;
            end
        endcase
        wr = wr && ok;
        @(posedge clk);
        op_valid   <= 1'b1;
        op_code    <= op;
        literal    <= k;
        file_addr  <= a;
        dest_sel   <= d;
        file_rdata <= f;
        ce         <= go;
        @(posedge clk);
        op_valid <= 1'b0;
        ce       <= 1'b1;
        #1;
        if (ok && !wr) begin
            e_acc = r;
        end
        chk("done", ok, done);
        chk("file_we", wr, file_we);
        chk("acc", e_acc, acc);
        chk("carry", e_c, carry);
        chk("digit_carry", e_digc, digit_carry);
        chk("zero", e_z, zero);
        if (wr) begin
            chk("file_waddr", a, file_waddr);
            chk("file_wdata", r, file_wdata);
        end
    endtask

    // Reset state of every output.
    task automatic t_reset();
        chk("acc", 8'h00, acc);
        chk("flags", 8'h00, {carry, digit_carry, zero});
        chk("strobes", 8'h00, {done, file_we});
        chk("file_waddr", 8'h00, file_waddr);
        chk("file_wdata", 8'h00, file_wdata);
    endtask

    // Literal subtract at equality, borrow and nibble-borrow boundaries; destination bit must be ignored.
    task automatic t_sub_lit();
        load(8'h10);
        run_op(3'h0, 8'h10, 7'h00, 1'b1, 8'h00, 1'b1);
        load(8'h21);
        run_op(3'h0, 8'h20, 7'h00, 1'b0, 8'h00, 1'b1);
        load(8'h0F);
        run_op(3'h0, 8'h10, 7'h00, 1'b0, 8'h00, 1'b1);
    endtask

    // File subtract to the top file address and to the accumulator.
    task automatic t_sub_file();
        load(8'h05);
        run_op(3'h1, 8'h00, 7'h7F, 1'b1, 8'h03, 1'b1);
        run_op(3'h1, 8'h00, 7'h00, 1'b0, 8'h05, 1'b1);
        load(8'h01);
        run_op(3'h1, 8'h00, 7'h11, 1'b0, 8'h80, 1'b1);
    endtask

    // XOR forms: carry flags must survive, zero follows the result.
    task automatic t_xor();
        load(8'h3C);
        run_op(3'h2, 8'h3C, 7'h00, 1'b1, 8'h00, 1'b1);
        run_op(3'h2, 8'hA5, 7'h00, 1'b0, 8'h00, 1'b1);
        run_op(3'h3, 8'h00, 7'h2A, 1'b1, 8'h55, 1'b1);
        run_op(3'h3, 8'h00, 7'h01, 1'b0, 8'hA5, 1'b1);
    endtask

    // Swap after a zero result, so a stray flag update would show.
    task automatic t_swap();
        load(8'h77);
        run_op(3'h2, 8'h77, 7'h00, 1'b0, 8'h00, 1'b1);
        run_op(3'h4, 8'h00, 7'h7F, 1'b1, 8'hA5, 1'b1);
        run_op(3'h4, 8'h00, 7'h10, 1'b0, 8'h3C, 1'b1);
    endtask

    // Disabled clock and unused codes must change nothing.
    task automatic t_refuse();
        run_op(3'h1, 8'h00, 7'h05, 1'b1, 8'h99, 1'b0);
        for (int i = 5; i < 8; i++) begin
            run_op(3'(i), 8'h12, 7'h05, 1'b1, 8'h34, 1'b1);
        end
    endtask

    // Back-to-back requests: the second must see the first's registered result.
    task automatic t_b2b();
        load(8'h5A);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= 3'h2;
        literal  <= 8'hFF;
        dest_sel <= 1'b0;
        @(posedge clk);
        op_code <= 3'h0;
        literal <= 8'h30;
        #1;
        chk("acc b2b first", 8'hA5, acc);
        chk("done b2b first", 8'h01, done);
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("acc b2b second", 8'h8B, acc);
        chk("flags b2b", 8'h00, {carry, digit_carry, zero});
        chk("done b2b second", 8'h01, done);
        e_acc  = 8'h8B;
        e_c    = 1'b0;
        e_digc = 1'b0;
        e_z   = 1'b0;
    endtask

    // Strobes stand while the clock enable is low, a load loses to a taken operation, and a
    // reset in mid-run brings every output back to its reset value.
    task automatic t_hold();
        load(8'h12);
        @(posedge clk);
        op_valid      <= 1'b1;
        op_code       <= 3'h3;
        file_addr     <= 7'h33;
        dest_sel      <= 1'b1;
        file_rdata    <= 8'h12;
        acc_load      <= 1'b1;
        acc_load_data <= 8'hEE;
        @(posedge clk);
        op_valid <= 1'b0;
        acc_load <= 1'b0;
        ce       <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("done frozen", 8'h01, done);
        chk("file_we frozen", 8'h01, file_we);
        chk("file_waddr frozen", 8'h33, file_waddr);
        chk("file_wdata frozen", 8'h00, file_wdata);
        chk("zero frozen", 8'h01, zero);
        chk("acc beside load", 8'h12, acc);
        @(posedge clk);
        ce      <= 1'b1;
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        t_reset();
        e_acc  = 8'h00;
        e_c    = 1'b0;
        e_digc = 1'b0;
        e_z    = 1'b0;
    endtask

    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        t_reset();
        t_sub_lit();
        t_sub_file();
        t_xor();
        t_swap();
        t_refuse();
        t_hold();
        t_b2b();
        print_verdict();
    end
endmodule

`default_nettype wire
